/* File: rtl/ccds_top.sv */
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "ccds_cfg.svh"
module ccds_top (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              reset_level_sample_clock,
  input  wire logic              data_level_sample_clock,
  input  wire logic              converter_sample_clock,
  input  wire ccds_pkg::ccds_pix3_t vin_code,
  input  wire logic [11:0]       offset_ref_code,
  input  wire logic              out_enable_n,
  output logic [11:0]            data_out,
  output logic                   data_oe,
  output logic                   data_valid,
  output ccds_pkg::ccds_ch_t     data_chan,
  output ccds_pkg::ccds_ch_t     mux_channel,
  output logic                   clamp_active
);
  import ccds_pkg::*;
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]       cfg;
    logic [7:0]       channel_multiplexer;
    logic [2:0][7:0]  gain;
    logic [2:0][7:0]  ofs;
    ccds_pix3_t       ref_lv;
    ccds_pix3_t       held;
    logic [1:0]       slot;
    logic [1:0]       fill;
    logic [11:0]      dout;
    ccds_ch_t         dchan;
    logic             dvalid;
    logic             doe;
    logic             clamp;
    ccds_ch_t         mch;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } ccds_core_st_t;
  ccds_core_st_t st_r;
  ccds_core_st_t st_nxt;
  ccds_link_if   lk ();
  logic          cds_on;
  logic          three_on;
  ccds_ch_t      cur_chan;
  logic [4:0]    hit;
  logic          wr_go;
  logic [1:0]    ord;
  logic [2:0]    sel;
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic ccds_is_cds(input logic [7:0] c);
    return c[`CCDS_CFG_CDS_BIT];
  endfunction
  // bit2 wins if both set; neither set falls back to three-channel
  function automatic logic ccds_is_3ch(input logic [7:0] c);
    return c[`CCDS_CFG_3CH_BIT] | ~c[`CCDS_CFG_1CH_BIT];
  endfunction
  function automatic ccds_ch_t ccds_order_ch(input logic [1:0] o, input logic [1:0] s);
    ccds_ch_t c;
    c = CCDS_CH_G;
    if (s == 2'h0) begin
      c = (o == `CCDS_ORD_BGR) ? CCDS_CH_B : CCDS_CH_R;
    end else if (s == `CCDS_SLOT_LAST) begin
      c = (o == `CCDS_ORD_BGR) ? CCDS_CH_R : CCDS_CH_B;
    end
    return c;
  endfunction
  // non one-hot patterns fall back to red
  function automatic ccds_ch_t ccds_sel_ch(input logic [2:0] s);
    ccds_ch_t c;
    c = CCDS_CH_R;
    if (s == `CCDS_SEL_G) begin
      c = CCDS_CH_G;
    end else if (s == `CCDS_SEL_B) begin
      c = CCDS_CH_B;
    end
    return c;
  endfunction
  // {valid, index}; word aligned, index 0..8
  function automatic logic [4:0] ccds_dec(input logic [7:0] a);
    logic ok;
    ok = (a[1:0] == 2'h0) && (a[7:2] <= {2'h0, `CCDS_IDX_STATUS});
    return {ok, a[5:2]};
  endfunction
  function automatic logic [11:0] ccds_diff(input logic [11:0] a, input logic [11:0] b);
    return (a > b) ? a - b : 12'h000;
  endfunction
  // sign-magnitude offset in lsb, then gain of 1 + code/51.2
  function automatic logic [11:0] ccds_scale(input logic [11:0] x, input logic [7:0] g,
                                             input logic [7:0] o);
    logic [12:0] s;
    logic [12:0] m;
    logic [25:0] p;
    if (o[7]) begin
      s = {1'b0, ccds_diff(x, {5'h00, o[6:0]})};
    end else begin
      s = {1'b0, x} + {6'h00, o[6:0]};
    end
    m = `CCDS_GAIN_UNITY + 13'({5'h00, g} * `CCDS_GAIN_STEP);
    p = 26'(s) * 26'(m);
    return (|p[25:21]) ? 12'hfff : p[20:9];
  endfunction
  // ----------------------------------------
  // submodules
  // ----------------------------------------
  ccds_edge u_edge (
    .clk    (clk),
    .srst   (srst),
    .rl_clk (reset_level_sample_clock),
    .dl_clk (data_level_sample_clock),
    .cv_clk (converter_sample_clock),
    .lk     (lk.edge_src)
  );
  ccds_pipe u_pipe (
    .clk  (clk),
    .srst (srst),
    .lk   (lk.pipe)
  );
  // ----------------------------------------
  // mode and channel selection
  // ----------------------------------------
  assign ord      = st_r.channel_multiplexer[`CCDS_MUX_ORD_HI:`CCDS_MUX_ORD_LO];
  assign sel      = st_r.channel_multiplexer[`CCDS_MUX_SEL_HI:`CCDS_MUX_SEL_LO];
  assign cds_on   = ccds_is_cds(st_r.cfg);
  assign three_on = ccds_is_3ch(st_r.cfg);
  assign cur_chan = three_on ? ccds_order_ch(ord, st_r.slot) : ccds_sel_ch(sel);
  assign hit      = ccds_dec(paddr);
  assign wr_go    = psel & penable & st_r.pready & pwrite & hit[4];
  assign lk.push  = lk.cv_fall;
  assign lk.din   = '{w: ccds_scale(st_r.held[cur_chan], st_r.gain[cur_chan], st_r.ofs[cur_chan]),
                      ch: cur_chan};
  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    // apb: one wait state, answer prepared in first access cycle
    st_nxt.pready  = 1'b0;
    st_nxt.pslverr = 1'b0;
    if (psel && penable && !st_r.pready) begin
      st_nxt.pready  = 1'b1;
      st_nxt.pslverr = ~hit[4];
      st_nxt.prdata  = 32'h0000_0000;
      if (hit[4]) begin
        unique case (hit[3:0])
          `CCDS_IDX_CFG:    st_nxt.prdata[7:0] = st_r.cfg;
          `CCDS_IDX_MUX:    st_nxt.prdata[7:0] = st_r.channel_multiplexer;
          `CCDS_IDX_STATUS: st_nxt.prdata[6:0] = {st_r.clamp, three_on, cds_on, st_r.mch, st_r.slot};
          default: begin
            if (hit[3:0] <= `CCDS_IDX_GAIN_B) begin
              st_nxt.prdata[7:0] = st_r.gain[2'(hit[3:0] - `CCDS_IDX_GAIN_R)];
            end else begin
              st_nxt.prdata[7:0] = st_r.ofs[2'(hit[3:0] - `CCDS_IDX_OFS_R)];
            end
          end
        endcase
      end
    end
    if (wr_go) begin
      if (hit[3:0] == `CCDS_IDX_CFG) begin
        st_nxt.cfg = pwdata[7:0];
      end else if (hit[3:0] == `CCDS_IDX_MUX) begin
        st_nxt.channel_multiplexer = pwdata[7:0];
      end else if (hit[3:0] >= `CCDS_IDX_GAIN_R && hit[3:0] <= `CCDS_IDX_GAIN_B) begin
        st_nxt.gain[2'(hit[3:0] - `CCDS_IDX_GAIN_R)] = pwdata[7:0];
      end else if (hit[3:0] >= `CCDS_IDX_OFS_R && hit[3:0] <= `CCDS_IDX_OFS_B) begin
        st_nxt.ofs[2'(hit[3:0] - `CCDS_IDX_OFS_R)] = pwdata[7:0];
      end
    end
    // clamp only in double sampling, following the reset pulse one clk later
    st_nxt.clamp = cds_on & reset_level_sample_clock;
    if (lk.rl_fall && cds_on) begin
      st_nxt.ref_lv = vin_code;
    end
    // all three inputs captured together in every mode
    if (lk.dl_fall) begin
      for (int i = 0; i < 3; i++) begin
        if (cds_on) begin
          st_nxt.held[i] = ccds_diff(st_r.ref_lv[i], vin_code[i]);
        end else begin
          st_nxt.held[i] = ccds_diff(vin_code[i], offset_ref_code);
        end
      end
    end
    st_nxt.dvalid = 1'b0;
    if (lk.cv_fall) begin
      st_nxt.dout   = lk.q.w;
      st_nxt.dchan  = lk.q.ch;
      st_nxt.dvalid = (st_r.fill == 2'(`CCDS_LAT));
      if (st_r.fill != 2'(`CCDS_LAT)) begin
        st_nxt.fill = st_r.fill + 2'h1;
      end
      if (three_on && st_r.slot != `CCDS_SLOT_LAST) begin
        st_nxt.slot = st_r.slot + 2'h1;
      end else begin
        st_nxt.slot = 2'h0;
      end
    end
    // pixel boundary wins over a coinciding step
    if (lk.dl_rise) begin
      st_nxt.slot = 2'h0;
    end
    st_nxt.mch = three_on ? ccds_order_ch(ord, st_nxt.slot) : ccds_sel_ch(sel);
    st_nxt.doe = ~out_enable_n;
    if (srst) begin
      st_nxt        = '0;
      st_nxt.cfg    = `CCDS_CFG_RST;
      st_nxt.channel_multiplexer    = `CCDS_MUX_RST;
      st_nxt.gain   = {3{`CCDS_GAIN_RST}};
      st_nxt.ofs    = {3{`CCDS_OFS_RST}};
      st_nxt.dchan  = CCDS_CH_R;
      st_nxt.mch    = CCDS_CH_R;
    end
  end
  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata       = st_r.prdata;
  assign pready       = st_r.pready;
  assign pslverr      = st_r.pslverr;
  assign data_out     = st_r.dout;
  assign data_oe      = st_r.doe;
  assign data_valid   = st_r.dvalid;
  assign data_chan    = st_r.dchan;
  assign mux_channel  = st_r.mch;
  assign clamp_active = st_r.clamp;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking ccds_cb @(posedge clk); endclocking
  default disable iff (srst);
  mode_write_a: assert property (wr_go && hit[3:0] == `CCDS_IDX_CFG |=> st_r.cfg == $past(pwdata[7:0]))
    else $error("configuration write lost");
  clamp_capture_a: assert property (lk.rl_fall && cds_on |=> st_r.ref_lv == $past(vin_code))
    else $error("reference not clamped");
  cds_diff_a: assert property (lk.dl_fall && cds_on |=>
                               st_r.held[1] == ccds_diff($past(st_r.ref_lv[1]), $past(vin_code[1])))
    else $error("difference wrong");
  sha_sample_a: assert property (lk.dl_fall && !cds_on |=>
                                 st_r.held[2] == ccds_diff($past(vin_code[2]), $past(offset_ref_code)))
    else $error("hold sample wrong");
  no_clamp_a: assert property (!ccds_is_cds($past(st_r.cfg)) |-> !clamp_active)
    else $error("clamp active in hold mode");
  conv_tag_a: assert property (lk.cv_fall |=> u_pipe.st_r.stg[0].ch == $past(cur_chan))
    else $error("conversion channel wrong");
  out_load_a: assert property (lk.cv_fall |=> data_out == $past(lk.q.w) && data_chan == $past(lk.q.ch))
    else $error("output not loaded");
  mux_reset_a: assert property (lk.dl_rise |=> st_r.slot == 2'h0)
    else $error("multiplexer not reset");
  bgr_order_a: assert property (three_on && ord == `CCDS_ORD_BGR && lk.dl_rise |=>
                                mux_channel == CCDS_CH_B)
    else $error("order wrong");
  one_ch_fix_a: assert property (!three_on |=> mux_channel == ccds_sel_ch($past(sel)))
    else $error("one-channel mux moved");
  // ----------------------------------------
  // bus checks
  // ----------------------------------------
  // exactly one wait state; a slip would only cost time, but the note promises it
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("answer held too long");
  bad_addr_a: assert property (psel && penable && !pready && !hit[4] |=> pslverr)
    else $error("unmapped address not refused");
  status_ro_a: assert property (wr_go && hit[3:0] == `CCDS_IDX_STATUS |=>
                                $stable(st_r.cfg) && $stable(st_r.channel_multiplexer))
    else $error("status write changed mode");
  gain_write_a: assert property (wr_go && hit[3:0] == `CCDS_IDX_GAIN_R |=>
                                 st_r.gain[0] == $past(pwdata[7:0]))
    else $error("gain write lost");
  // ----------------------------------------
  // sampling and stream checks
  // ----------------------------------------
  clamp_rise_a: assert property (cds_on && reset_level_sample_clock |=> clamp_active)
    else $error("clamp missing");
  ref_hold_a: assert property (!(lk.rl_fall && cds_on) |=> $stable(st_r.ref_lv))
    else $error("reference moved outside clamp");
  sha_no_ref_a: assert property (lk.rl_fall && !cds_on |=> $stable(st_r.ref_lv))
    else $error("reference taken in hold mode");
  held_hold_a: assert property (!lk.dl_fall |=> $stable(st_r.held))
    else $error("held level moved between samples");
  // unity gain and zero offset must pass the held level through untouched
  scale_unity_a: assert property (lk.cv_fall && st_r.gain[cur_chan] == 8'h00 &&
                                  st_r.ofs[cur_chan][6:0] == 7'h00 |=>
                                  u_pipe.st_r.stg[0].w == $past(st_r.held[cur_chan]))
    else $error("scaling not transparent");
  rgb_order_a: assert property (three_on && ord == `CCDS_ORD_RGB && lk.dl_rise |=>
                                mux_channel == CCDS_CH_R)
    else $error("pixel not starting on red");
  sel_blue_a: assert property (!three_on && sel == `CCDS_SEL_B |=>
                               mux_channel == CCDS_CH_B)
    else $error("blue select ignored");
  slot_step_a: assert property (three_on && lk.cv_fall && !lk.dl_rise && st_r.slot == 2'h0 |=>
                                st_r.slot == 2'h1)
    else $error("multiplexer did not step");
  slot_range_a: assert property (st_r.slot <= `CCDS_SLOT_LAST)
    else $error("slot out of range");
  one_ch_slot_a: assert property (!three_on && lk.cv_fall |=> st_r.slot == 2'h0)
    else $error("one-channel slot moved");
  // stages not yet filled after reset hold stale words, so they stay unflagged
  warm_up_a: assert property (lk.cv_fall && st_r.fill != 2'(`CCDS_LAT) |=> !data_valid)
    else $error("unfilled word flagged");
  valid_pulse_a: assert property (data_valid |=> !data_valid)
    else $error("valid longer than one cycle");
  valid_src_a: assert property (data_valid |-> $past(lk.cv_fall))
    else $error("valid without conversion");
  three_cds_c: cover property (three_on && cds_on && lk.cv_fall && st_r.slot == `CCDS_SLOT_LAST);
  one_ch_c:    cover property (!three_on && data_valid);
  sha_c:       cover property (!cds_on && lk.dl_fall);
  bgr_c:       cover property (three_on && ord == `CCDS_ORD_BGR && data_valid);
  one_sha_c:   cover property (!cds_on && !three_on && data_valid);
endmodule

/* File: inc/ccds_cfg.svh */
`ifndef CCDS_CFG_SVH
`define CCDS_CFG_SVH
// ----------------------------------------
// register indices (byte address = 4 x index)
// ----------------------------------------
`define CCDS_IDX_CFG      4'h0
`define CCDS_IDX_MUX      4'h1
`define CCDS_IDX_GAIN_R   4'h2
`define CCDS_IDX_GAIN_B   4'h4
`define CCDS_IDX_OFS_R    4'h5
`define CCDS_IDX_OFS_B    4'h7
`define CCDS_IDX_STATUS   4'h8
// ----------------------------------------
// field positions
// ----------------------------------------
`define CCDS_CFG_CDS_BIT  5
`define CCDS_CFG_3CH_BIT  2
`define CCDS_CFG_1CH_BIT  1
`define CCDS_MUX_ORD_HI   6
`define CCDS_MUX_ORD_LO   5
`define CCDS_MUX_SEL_HI   4
`define CCDS_MUX_SEL_LO   2
`define CCDS_ORD_RGB      2'h1
`define CCDS_ORD_BGR      2'h2
`define CCDS_SEL_G        3'h2
`define CCDS_SEL_B        3'h4
// ----------------------------------------
// reset values
// ----------------------------------------
`define CCDS_CFG_RST      8'h34
`define CCDS_MUX_RST      8'h21
`define CCDS_GAIN_RST     8'h00
`define CCDS_OFS_RST      8'h00
// ----------------------------------------
// timing and scaling
// ----------------------------------------
`define CCDS_LAT          3
`define CCDS_SLOT_LAST    2'h2
`define CCDS_GAIN_UNITY   13'h0200
`define CCDS_GAIN_STEP    13'h000a
`endif

/* File: inc/ccds_pkg.sv */
package ccds_pkg;
  typedef logic [2:0][11:0] ccds_pix3_t;
  typedef enum logic [1:0] {CCDS_CH_R, CCDS_CH_G, CCDS_CH_B} ccds_ch_t;
  typedef struct packed {
    logic [11:0] w;
    ccds_ch_t    ch;
  } ccds_conv_t;
endpackage

/* File: inc/ccds_if.sv */
`timescale 1ns/10ps
interface ccds_link_if;
  import ccds_pkg::*;
  logic       rl_fall;
  logic       dl_rise;
  logic       dl_fall;
  logic       cv_fall;
  logic       push;
  ccds_conv_t din;
  ccds_conv_t q;
  modport edge_src (output rl_fall, dl_rise, dl_fall, cv_fall);
  modport pipe     (input push, din, output q);
  modport core     (input rl_fall, dl_rise, dl_fall, cv_fall, q, output push, din);
endinterface

/* File: rtl/ccds_edge.sv */
`timescale 1ns/10ps
module ccds_edge (
  input wire logic    clk,
  input wire logic    srst,
  input wire logic    rl_clk,
  input wire logic    dl_clk,
  input wire logic    cv_clk,
  ccds_link_if.edge_src lk
);
  import ccds_pkg::*;
  typedef struct packed {
    logic rl;
    logic dl;
    logic cv;
  } ccds_edge_st_t;
  ccds_edge_st_t st_r;
  ccds_edge_st_t st_nxt;
  // ----------------------------------------
  // previous pin levels
  // ----------------------------------------
  always_comb begin
    st_nxt = '{rl: rl_clk, dl: dl_clk, cv: cv_clk};
    if (srst) begin
      st_nxt = '0;
    end
  end
  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end
  // pins are synchronous, so edges are plain compares
  assign lk.rl_fall = st_r.rl & ~rl_clk;
  assign lk.dl_rise = ~st_r.dl & dl_clk;
  assign lk.dl_fall = st_r.dl & ~dl_clk;
  assign lk.cv_fall = st_r.cv & ~cv_clk;
endmodule

/* File: rtl/ccds_pipe.sv */
`timescale 1ns/10ps
`include "ccds_cfg.svh"
module ccds_pipe (
  input wire logic clk,
  input wire logic srst,
  ccds_link_if.pipe lk
);
  import ccds_pkg::*;
  typedef struct packed {
    ccds_conv_t [`CCDS_LAT-1:0] stg;
  } ccds_pipe_st_t;
  ccds_pipe_st_t st_r;
  ccds_pipe_st_t st_nxt;
  // ----------------------------------------
  // latency stages, advanced per conversion
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (lk.push) begin
      st_nxt.stg[0] = lk.din;
      for (int i = 1; i < `CCDS_LAT; i++) begin
        st_nxt.stg[i] = st_r.stg[i-1];
      end
    end
    if (srst) begin
      st_nxt = '0;
    end
  end
  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end
  assign lk.q = st_r.stg[`CCDS_LAT-1];
  default clocking ccds_pcb @(posedge clk); endclocking
  default disable iff (srst);
  stage_shift_a: assert property (lk.push |=> st_r.stg[1] == $past(st_r.stg[0]))
    else $error("pipe stage did not shift");
endmodule

/* File: sim/ccds_tgen.sv */
`timescale 1ns/10ps
module ccds_tgen (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 cds_on,
  input  wire ccds_pkg::ccds_pix3_t ref_lv,
  input  wire ccds_pkg::ccds_pix3_t dat_lv,
  output logic                      rl_clk,
  output logic                      dl_clk,
  output logic                      cv_clk,
  output ccds_pkg::ccds_pix3_t      vin
);
  import ccds_pkg::*;
  // ----------------------------------------
  // pixel phase, 12 clk a pixel
  // ----------------------------------------
  logic [3:0] ph_r;
  logic       on_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      ph_r <= 4'h0;
      on_r <= 1'b0;
    end else begin
      ph_r <= (ph_r == 4'hb) ? 4'h0 : ph_r + 4'h1;
      on_r <= 1'b1;
    end
  end
  // ----------------------------------------
  // pin levels
  // ----------------------------------------
  // one master rate in every mode, conversions every 4 clk
  assign cv_clk = ~ph_r[1];
  // rises after the fall at phase 10, 200ns wide, well under 400ns less 30ns
  assign dl_clk = on_r & ((ph_r == 4'hb) | (ph_r == 4'h0));
  // falls with the converter fall, two clk after its rise; alignment is only advised
  assign rl_clk = on_r & cds_on & ((ph_r == 4'h8) | (ph_r == 4'h9));
  // reference level held one clk past the clamp fall
  assign vin = (cds_on && ph_r >= 4'h8 && ph_r <= 4'ha) ? ref_lv : dat_lv;
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import ccds_pkg::*;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        rl_clk, dl_clk, cv_clk, oen_n, data_oe, data_valid, clamp, cds_on, err;
  ccds_pix3_t  vin, ref_lv, dat_lv;
  logic [11:0] ofs_code, data_out;
  ccds_ch_t    data_chan, mux_ch;
  ccds_conv_t  wq[$];
  int          fail_count, n_checks;

  always #50 clk = ~clk;

  ccds_top dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_level_sample_clock(rl_clk), .data_level_sample_clock(dl_clk),
    .converter_sample_clock(cv_clk), .vin_code(vin), .offset_ref_code(ofs_code),
    .out_enable_n(oen_n), .data_out(data_out), .data_oe(data_oe), .data_valid(data_valid),
    .data_chan(data_chan), .mux_channel(mux_ch), .clamp_active(clamp));

  ccds_tgen tgen (.clk(clk), .srst(srst), .cds_on(cds_on), .ref_lv(ref_lv), .dat_lv(dat_lv),
    .rl_clk(rl_clk), .dl_clk(dl_clk), .cv_clk(cv_clk), .vin(vin));

  // ----------------------------------------
  // capture: words tagged by data_chan
  // ----------------------------------------
  always @(negedge clk) begin
    if (data_valid === 1'b1) begin
      wq.push_back(ccds_conv_t'{w: data_out, ch: data_chan});
    end
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task cmp_word(input ccds_conv_t got, input ccds_conv_t exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------
  // apb master
  // ----------------------------------------
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      give_verdict;
    end
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
    apb(1'b0, a, 32'h0000_0000);
    cmp_reg(rd, exp);
    cmp_reg({31'h0000_0000, err}, {31'h0000_0000, eerr});
  endtask

  // ----------------------------------------
  // stream check: flush, align on pixel start, six words
  // ----------------------------------------
  task words(input ccds_ch_t c0, c1, c2, input logic [11:0] e0, e1, e2, input int ncl);
    ccds_ch_t    cs[3];
    logic [11:0] es[3];
    int          i;
    int          k;
    cs = '{c0, c1, c2};
    es = '{e0, e1, e2};
    // old-mode words still in the three-deep pipe
    repeat (36) @(posedge clk);
    @(posedge dl_clk);
    repeat (2) @(posedge clk);
    cmp_reg({30'h0000_0000, mux_ch}, {30'h0000_0000, c0});
    wq.delete();
    k = 0;
    for (i = 0; i < 12; i++) begin
      @(posedge clk);
      k += (clamp === 1'b1);
    end
    cmp_reg(k, ncl);
    for (i = 0; i < 200 && wq.size() < 6; i++) @(posedge clk);
    cmp_reg(wq.size(), 6);
    for (i = 0; i < 6; i++) cmp_word(wq[i], ccds_conv_t'{w: es[i % 3], ch: cs[i % 3]});
  endtask

  initial begin
    clk = 0;
    srst = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    oen_n = 1;
    cds_on = 1;
    ofs_code = 12'h0100;
    ref_lv = {12'h0800, 12'h0800, 12'h0800};
    dat_lv = {12'h0500, 12'h0600, 12'h0700};
    fail_count = 0;
    n_checks = 0;
    repeat (10) @(posedge clk);
    srst <= 0;
    rdc(8'h00, 32'h0000_0034, 1'b0);
    rdc(8'h04, 32'h0000_0021, 1'b0);
    rdc(8'h24, 32'h0000_0000, 1'b1);
    apb(1'b1, 8'h20, 32'h0000_00ff);
    rdc(8'h00, 32'h0000_0034, 1'b0);
    oen_n <= 0;
    repeat (2) @(posedge clk);
    cmp_reg({31'h0000_0000, data_oe}, 32'h0000_0001);
    words(CCDS_CH_R, CCDS_CH_G, CCDS_CH_B, 12'h0100, 12'h0200, 12'h0300, 2);
    apb(1'b1, 8'h04, 32'h0000_0041);
    words(CCDS_CH_B, CCDS_CH_G, CCDS_CH_R, 12'h0300, 12'h0200, 12'h0100, 2);
    cds_on <= 0;
    apb(1'b1, 8'h00, 32'h0000_0014);
    words(CCDS_CH_B, CCDS_CH_G, CCDS_CH_R, 12'h0400, 12'h0500, 12'h0600, 0);
    apb(1'b1, 8'h04, 32'h0000_0009);
    apb(1'b1, 8'h00, 32'h0000_0002);
    words(CCDS_CH_G, CCDS_CH_G, CCDS_CH_G, 12'h0500, 12'h0500, 12'h0500, 0);
    cds_on <= 1;
    apb(1'b1, 8'h04, 32'h0000_0011);
    apb(1'b1, 8'h00, 32'h0000_0022);
    words(CCDS_CH_B, CCDS_CH_B, CCDS_CH_B, 12'h0300, 12'h0300, 12'h0300, 2);
    apb(1'b1, 8'h00, 32'h0000_0034);
    apb(1'b1, 8'h04, 32'h0000_0021);
    // gain code 0x33: 256 x 1022 >> 9 = 0x1ff; offsets +16 on green, -5 on blue
    apb(1'b1, 8'h08, 32'h0000_0033);
    apb(1'b1, 8'h18, 32'h0000_0010);
    apb(1'b1, 8'h1c, 32'h0000_0085);
    rdc(8'h08, 32'h0000_0033, 1'b0);
    rdc(8'h1c, 32'h0000_0085, 1'b0);
    words(CCDS_CH_R, CCDS_CH_G, CCDS_CH_B, 12'h01ff, 12'h0210, 12'h02fb, 2);
    give_verdict;
  end

  // ----------------------------------------
  // watchdog, about ten times the expected run
  // ----------------------------------------
  initial begin
    #500000;
    fail_count++;
    give_verdict;
  end
endmodule
